// ---- core/dsli_top.sv ----
// serial load front end of a 12-bit multiplying converter
`timescale 1ns/10ps
// Notes on behaviour
// - reset clears shift register, converter register and edge select to zero
// - sample data on falling serial clock by default; a control word selects rising
// - every serial word enters a 16-bit input shift register
// - frame select low opens the frame; clock and data are ignored while high
// - count active edges after frame select falls; latch on the sixteenth
// - serial output changes on the edge opposite the sampling edge
// - shift register msb drives the serial output for cascading devices
// - readback word loads converter register into shift register for shifting out
// - converter register updates only when a whole frame is latched
// - converter register holds 12-bit code from the low bits of the word
module dsli_top
  import dsli_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      srst,
  input  wire logic                      sclk,
  input  wire logic                      sync_n,
  input  wire logic                      serial_data_in,
  output logic                           serial_data_out,
  output logic [dsli_pkg::CODE_W-1:0]    dac_code,
  output logic                           sample_rising
);
  import dsli_pkg::*;

  // ==========================================================================
  // pin synchronisers
  dsli_pin_if pins ();

  dsli_pin_sync u_pin_sync (
    .clk        (clk),
    .srst       (srst),
    .sclk_pin   (sclk),
    .sync_n_pin (sync_n),
    .din_pin    (serial_data_in),
    .sig        (pins.drive)
  );

  // ==========================================================================
  // frame state
  dsli_state_t       state_q;
  dsli_state_t       state_d;
  logic [CNT_W-1:0]  cnt_q;
  logic [CNT_W-1:0]  cnt_d;
  logic [WORD_W-1:0] shift_q;
  logic [WORD_W-1:0] shift_d;
  logic [CODE_W-1:0] dac_q;
  logic [CODE_W-1:0] dac_d;
  logic              edge_rise_q;
  logic              edge_rise_d;
  logic              dout_q;
  logic              dout_d;

  logic              act_edge;
  logic              out_edge;
  logic              in_frame;
  logic              last_bit;
  logic [WORD_W-1:0] word_in;
  logic [CMD_W-1:0]  cmd;

  always_comb begin
    act_edge = edge_rise_q ? pins.sclk_rise : pins.sclk_fall;
    out_edge = edge_rise_q ? pins.sclk_fall : pins.sclk_rise;
    in_frame = (state_q != ST_IDLE) && !pins.sync_n_lvl;
    word_in  = {shift_q[WORD_W-2:0], pins.din_lvl};
    last_bit = act_edge && in_frame && (state_q == ST_SHIFT) && (cnt_q == LAST_CNT);
    cmd      = word_in[CMD_MSB:CMD_LSB];
  end

  // ==========================================================================
  // next-state logic
  always_comb begin
    state_d     = state_q;
    cnt_d       = cnt_q;
    shift_d     = shift_q;
    dac_d       = dac_q;
    edge_rise_d = edge_rise_q;
    dout_d      = dout_q;
    case (state_q)
      ST_IDLE: begin
        if (!pins.sync_n_lvl) begin
          state_d = ST_SHIFT;
          cnt_d   = CNT_RST;
        end
      end
      ST_SHIFT: begin
        if (pins.sync_n_lvl) begin
          state_d = ST_IDLE;
        end else if (act_edge) begin
          shift_d = word_in;
          cnt_d   = cnt_q + 4'h1;
          if (cnt_q == LAST_CNT) begin
            state_d = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        if (pins.sync_n_lvl) begin
          state_d = ST_IDLE;
        end else if (act_edge) begin
          shift_d = word_in;  // extra bits pass on to the next device
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // latch of a complete word
    if (last_bit) begin
      case (cmd)
        CMD_LOAD: begin
          dac_d = word_in[CODE_W-1:0];
        end
        CMD_READBACK: begin
          shift_d = {RB_PAD, dac_q};
        end
        CMD_EDGE_RISE: begin
          edge_rise_d = 1'b1;
        end
        CMD_EDGE_FALL: begin
          edge_rise_d = 1'b0;
        end
        default: begin
          dac_d = dac_q;
        end
      endcase
    end
    if (in_frame && out_edge) begin
      dout_d = shift_q[WORD_W-1];
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q     <= ST_IDLE;
      cnt_q       <= CNT_RST;
      shift_q     <= SHIFT_RST;
      dac_q       <= CODE_RST;
      edge_rise_q <= EDGE_RST;
      dout_q      <= 1'b0;
    end else begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      shift_q     <= shift_d;
      dac_q       <= dac_d;
      edge_rise_q <= edge_rise_d;
      dout_q      <= dout_d;
    end
  end

  // ==========================================================================
  // outputs
  assign serial_data_out = dout_q;
  assign dac_code        = dac_q;
  assign sample_rising   = edge_rise_q;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  chk_reset_clears: assert property (
    @(posedge clk) disable iff (1'b0)
    srst |=> (dac_q == CODE_RST) && (shift_q == SHIFT_RST) && !dout_q && !edge_rise_q)
    else $error("reset did not clear state");

  chk_edge_default: assert property (
    (in_frame && !sample_rising && pins.sclk_rise) |=> $stable(shift_q))
    else $error("rising serial clock moved data in falling mode");

  chk_shift_in: assert property (
    (act_edge && in_frame && !(last_bit && cmd == CMD_READBACK))
    |=> shift_q == {$past(shift_q[WORD_W-2:0]), $past(pins.din_lvl)})
    else $error("input bit not shifted in");

  chk_idle_stable: assert property (
    pins.sync_n_lvl |=> $stable(shift_q) && $stable(dac_q))
    else $error("state moved with frame select high");

  chk_latch_load: assert property (
    (last_bit && cmd == CMD_LOAD) |=> dac_code == $past(word_in[CODE_W-1:0]))
    else $error("sixteenth edge did not load code");

  chk_dout_edge: assert property (
    !(in_frame && out_edge) |=> $stable(serial_data_out))
    else $error("serial output moved off its edge");

  chk_dout_msb: assert property (
    (in_frame && out_edge) |=> serial_data_out == $past(shift_q[WORD_W-1]))
    else $error("serial output not shift msb");

  chk_readback: assert property (
    (last_bit && cmd == CMD_READBACK) |=> shift_q == {RB_PAD, $past(dac_q)})
    else $error("readback did not load shift register");

  chk_dac_hold: assert property (
    !last_bit |=> $stable(dac_code))
    else $error("converter register changed without latch");

  cov_load: cover property (last_bit && cmd == CMD_LOAD);
  cov_readback: cover property ((last_bit && cmd == CMD_READBACK) ##[1:600] out_edge);
  chk_count_step: assert property (
    (state_q == ST_SHIFT && in_frame && act_edge) |=> cnt_q == $past(cnt_q) + 4'h1)
    else $error("active edge not counted");

  chk_early_done: assert property (
    (state_q == ST_SHIFT && !last_bit) |=> state_q != ST_DONE)
    else $error("frame completed before sixteenth edge");

  chk_code_only_load: assert property (
    (last_bit && cmd != CMD_LOAD) |=> $stable(dac_code))
    else $error("converter register changed by non-load word");

  cov_rise_sel: cover property (last_bit && cmd == CMD_EDGE_RISE);
  cov_partial: cover property ($rose(pins.sync_n_lvl) && state_q == ST_SHIFT);
endmodule : dsli_top

// ---- core/dsli_pkg.sv ----
// constants for the converter serial load interface
package dsli_pkg;
  // ==========================================================================
  // word layout
  localparam int          WORD_W   = 16;
  localparam int          CODE_W   = 12;
  localparam int          CNT_W    = 4;
  localparam int          CMD_MSB  = 15;
  localparam int          CMD_LSB  = 12;
  localparam int          CMD_W    = 4;
  localparam int          PAD_W    = WORD_W - CODE_W;
  localparam int          SYNC_W   = 3;

  // ==========================================================================
  // counts and reset values
  localparam logic [CNT_W-1:0]  LAST_CNT     = 4'hF;
  localparam logic [CNT_W-1:0]  CNT_RST      = 4'h0;
  localparam logic [WORD_W-1:0] SHIFT_RST    = 16'h0000;
  localparam logic [CODE_W-1:0] CODE_RST     = 12'h000;
  localparam logic [PAD_W-1:0]  RB_PAD       = 4'h0;
  localparam logic              EDGE_RST     = 1'b0;
  localparam logic [SYNC_W-1:0] PIN_RST      = 3'h2;

  // ==========================================================================
  // control words in the top nibble
  localparam logic [CMD_W-1:0]  CMD_NOP       = 4'h0;
  localparam logic [CMD_W-1:0]  CMD_LOAD      = 4'h1;
  localparam logic [CMD_W-1:0]  CMD_READBACK  = 4'h2;
  localparam logic [CMD_W-1:0]  CMD_EDGE_RISE = 4'h9;
  localparam logic [CMD_W-1:0]  CMD_EDGE_FALL = 4'hA;

  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_DONE} dsli_state_t;
endpackage : dsli_pkg

// ---- core/dsli_pin_if.sv ----
// synchronised pin levels and edge pulses between the pin stage and the core
`timescale 1ns/10ps
interface dsli_pin_if;
  logic sclk_rise;
  logic sclk_fall;
  logic sync_n_lvl;
  logic din_lvl;

  modport drive (output sclk_rise, output sclk_fall, output sync_n_lvl, output din_lvl);
  modport take  (input  sclk_rise, input  sclk_fall, input  sync_n_lvl, input  din_lvl);
endinterface : dsli_pin_if

// ---- core/dsli_pin_sync.sv ----
// two-flop synchronisers for the three serial pins plus serial clock edge detect
`timescale 1ns/10ps
module dsli_pin_sync
  import dsli_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   srst,
  input  wire logic   sclk_pin,
  input  wire logic   sync_n_pin,
  input  wire logic   din_pin,
  dsli_pin_if.drive   sig
);
  // bit 0 sclk, bit 1 sync_n, bit 2 data
  logic [SYNC_W-1:0] meta_q;
  logic [SYNC_W-1:0] meta_d;
  logic [SYNC_W-1:0] lvl_q;
  logic [SYNC_W-1:0] lvl_d;
  logic              sclk_old_q;
  logic              sclk_old_d;

  always_comb begin
    meta_d     = {din_pin, sync_n_pin, sclk_pin};
    lvl_d      = meta_q;
    sclk_old_d = lvl_q[0];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q     <= PIN_RST;
      lvl_q      <= PIN_RST;
      sclk_old_q <= 1'b0;
    end else begin
      meta_q     <= meta_d;
      lvl_q      <= lvl_d;
      sclk_old_q <= sclk_old_d;
    end
  end

  assign sig.sclk_rise  = lvl_q[0] & ~sclk_old_q;
  assign sig.sclk_fall  = ~lvl_q[0] & sclk_old_q;
  assign sig.sync_n_lvl = lvl_q[1];
  assign sig.din_lvl    = lvl_q[2];
endmodule : dsli_pin_sync

// ---- verif/dsli_host_model.sv ----
// host serial controller model driving frame select, serial clock and data
`timescale 1ns/10ps
module dsli_host_model (
  input  wire logic clk,
  input  wire logic dout,
  output logic      sclk,
  output logic      sync_n,
  output logic      din
);
  initial begin
    sclk   = 1'b0;
    sync_n = 1'b1;
    din    = 1'b0;
  end

  // ==========================================================================
  // one frame of n bits; opn low keeps frame select high throughout
  task automatic frame(input logic [15:0] w, input int n, input logic rise,
                       input logic opn, output logic [15:0] cap);
    cap = 16'h0000;
    @(posedge clk);
    // park the clock on the active level while select is still high
    sclk   <= rise;
    repeat (4) @(posedge clk);
    sync_n <= ~opn;
    repeat (25) @(posedge clk);
    for (int i = 15; i > 15 - n; i--) begin
      sclk <= ~rise;
      din  <= w[i];
      repeat (12) @(posedge clk);
      cap[i] = dout;
      sclk <= rise;
      repeat (13) @(posedge clk);
    end
    sync_n <= 1'b1;
    // released data line shows no stale level
    din    <= ~din;
    repeat (25) @(posedge clk);
  endtask : frame
endmodule : dsli_host_model

// ---- verif/dsli_top_tb.sv ----
// self-checking bench for the converter serial load front end
`timescale 1ns/10ps
module dsli_top_tb;
  import dsli_pkg::*;
  logic              clk;
  logic              srst;
  logic              sclk;
  logic              sync_n;
  logic              din;
  logic              dout;
  logic              smp_rise;
  logic [CODE_W-1:0] code;
  logic [15:0]       cap;
  int                errors;
  int                checks_done;
  int                cyc;

  dsli_top dsli_top_i (.clk(clk), .srst(srst), .sclk(sclk), .sync_n(sync_n),
    .serial_data_in(din), .serial_data_out(dout), .dac_code(code),
    .sample_rising(smp_rise));
  dsli_host_model dsli_host_model_i (.clk(clk), .dout(dout), .sclk(sclk),
    .sync_n(sync_n), .din(din));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ==========================================================================
  // comparison and verdict
  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic results;
    if (errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end

  // ==========================================================================
  // scenarios
  task automatic t_reset;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    check("code", 16'h0000, {4'h0, code});
    check("dout", 16'h0000, {15'h0000, dout});
    check("edge", 16'h0000, {15'h0000, smp_rise});
  endtask : t_reset

  task automatic t_load;
    dsli_host_model_i.frame(16'h1A5C, 16, 1'b0, 1'b1, cap);
    check("load", 16'h0A5C, {4'h0, code});
  endtask : t_load

  task automatic t_readback;
    dsli_host_model_i.frame(16'h2000, 16, 1'b0, 1'b1, cap);
    check("chain", 16'h1A5C, cap);
    check("hold", 16'h0A5C, {4'h0, code});
    dsli_host_model_i.frame(16'h0000, 16, 1'b0, 1'b1, cap);
    check("readback", 16'h0A5C, cap);
  endtask : t_readback

  task automatic t_refuse;
    dsli_host_model_i.frame(16'h1FFF, 10, 1'b0, 1'b1, cap);
    check("partial", 16'h0A5C, {4'h0, code});
    dsli_host_model_i.frame(16'h1FFF, 16, 1'b0, 1'b0, cap);
    check("closed", 16'h0A5C, {4'h0, code});
  endtask : t_refuse

  task automatic t_edge;
    dsli_host_model_i.frame(16'h9000, 16, 1'b0, 1'b1, cap);
    check("to_rise", 16'h0001, {15'h0000, smp_rise});
    dsli_host_model_i.frame(16'h1321, 16, 1'b1, 1'b1, cap);
    check("rise_load", 16'h0321, {4'h0, code});
    check("rise_dout", 16'h9000, cap);
    dsli_host_model_i.frame(16'hA000, 16, 1'b1, 1'b1, cap);
    check("to_fall", 16'h0000, {15'h0000, smp_rise});
    dsli_host_model_i.frame(16'h1777, 16, 1'b0, 1'b1, cap);
    check("fall_load", 16'h0777, {4'h0, code});
  endtask : t_edge

  task automatic t_rerun;
    dsli_host_model_i.frame(16'h9000, 16, 1'b0, 1'b1, cap);
    check("fall_dout", 16'h1777, cap);
    srst <= 1'b1;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    check("rst_code", 16'h0000, {4'h0, code});
    check("rst_edge", 16'h0000, {15'h0000, smp_rise});
    check("rst_dout", 16'h0000, {15'h0000, dout});
    dsli_host_model_i.frame(16'h1000, 16, 1'b0, 1'b1, cap);
    check("rst_shift", 16'h0000, cap);
  endtask : t_rerun

  initial begin
    srst        = 1'b1;
    errors      = 0;
    checks_done = 0;
    cyc         = 0;
    t_reset();
    t_load();
    t_readback();
    t_refuse();
    t_edge();
    t_rerun();
    results();
  end
endmodule : dsli_top_tb
